// [verilog/adcs_pkg.sv]
// Shared constants and types for the converter sequencer control block.
// Assumes a single 40 MHz system clock and an AHB-Lite register port.
`default_nettype none
package adcs_pkg;
	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] ADCS_OFS_INPUT_SELECT = 8'h00;
	localparam logic [7:0] ADCS_OFS_CONTROL      = 8'h04;
	localparam logic [7:0] ADCS_OFS_RESULT_LOW   = 8'h08;
	localparam logic [7:0] ADCS_OFS_RESULT_HIGH  = 8'h0c;
	localparam logic [7:0] ADCS_RST_INPUT_SELECT = 8'h00;
	localparam logic [7:0] ADCS_RST_CONTROL      = 8'h00;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned ADCS_BIT_REF_HI   = 7;
	localparam int unsigned ADCS_BIT_REF_LO   = 6;
	localparam int unsigned ADCS_BIT_LEFT     = 5;
	localparam int unsigned ADCS_BIT_CHAN_HI  = 3;
	localparam int unsigned ADCS_BIT_ENABLE   = 7;
	localparam int unsigned ADCS_BIT_START    = 6;
	localparam int unsigned ADCS_BIT_FREE     = 5;
	localparam int unsigned ADCS_BIT_FLAG     = 4;
	localparam int unsigned ADCS_BIT_IRQ_EN   = 3;
	localparam int unsigned ADCS_BIT_DIV_HI   = 2;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] ADCS_REF_EXTERNAL = 2'h0;
	localparam logic [1:0] ADCS_REF_SUPPLY   = 2'h1;
	localparam logic [1:0] ADCS_REF_RESERVED = 2'h2;
	localparam logic [1:0] ADCS_REF_INTERNAL = 2'h3;
	localparam logic [3:0] ADCS_CH_EXT_LAST  = 4'h7;
	localparam logic [3:0] ADCS_CH_BANDGAP   = 4'he;
	localparam logic [3:0] ADCS_CH_GROUND    = 4'hf;
	localparam logic [1:0] ADCS_HTRANS_NONSEQ = 2'h2;

	// ****************************************************************
	// Result width, and conversion timing in converter clock cycles
	// ****************************************************************
	localparam int unsigned ADCS_RES_W     = 10;
	localparam logic [4:0] ADCS_CYC_FIRST  = 5'h19;
	localparam logic [4:0] ADCS_CYC_NORMAL = 5'h0d;
	localparam logic [4:0] ADCS_EXTRA      = ADCS_CYC_FIRST - ADCS_CYC_NORMAL;
	localparam logic [4:0] ADCS_SH_CYC     = 5'h01;
	localparam logic [4:0] ADCS_STEP_FIRST = 5'h02;
	localparam logic [4:0] ADCS_STEP_LAST  = 5'h0b;

	typedef enum logic [1:0] {
		ADCS_IDLE = 2'b00,
		ADCS_CONV = 2'b01
	} adcs_state_e;
endpackage
`default_nettype wire

// [verilog/adcs_prescaler.sv]
// Converter clock enable generator from the system clock.
// Assumes the caller holds enable low while the converter is off.
`default_nettype none
module adcs_prescaler (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Control
	input  wire logic       enable,
	input  wire logic [2:0] sel,
	// Converter clock enable
	output var  logic       tick
);
	import adcs_pkg::*;

	// ****************************************************************
	// Divider
	// ****************************************************************
	logic [6:0] cnt_r;
	logic [7:0] one_sh;
	logic [6:0] mask;

	// Codes zero and one both divide by two
	assign one_sh = 8'h01 << sel;
	assign mask   = (sel == 3'h0) ? 7'h01 : one_sh[6:0] - 7'h01; // [RQ14]

	// Free-running count, held clear while disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= 7'h00;
			tick  <= 1'b0;
		end else begin
			cnt_r <= enable ? cnt_r + 7'h01 : 7'h00; // [RQ20]
			tick  <= enable && ((cnt_r & mask) == mask); // [RQ14]
		end
	end

	// Divide by eight gives seven quiet cycles after each pulse
	div_eight_a: assert property (@(posedge clk) disable iff (!arst_n) // [RQ14]
		(tick && enable && sel == 3'h3 && $stable(sel)) |=>
		(!tick)[*7] ##1 (tick || !enable || sel != 3'h3))
		else $error("divider pulse spacing wrong");
endmodule
`default_nettype wire

// [verilog/adcs_sar.sv]
// Successive approximation register driving the trial DAC code.
// Assumes comp is synchronised and high when input >= trial level.
`default_nettype none
module adcs_sar #(
	parameter int unsigned W = 10
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Sequencing
	input  wire logic         load,
	input  wire logic         step,
	input  wire logic         comp,
	// Trial code, final after the last step
	output var  logic [W-1:0] code
);
	import adcs_pkg::*;

	// ****************************************************************
	// Bit search
	// ****************************************************************
	logic [W-1:0] bit_r;
	logic [W-1:0] keep;
	logic [W-1:0] next_bit;
	logic [W-1:0] msb;

	// Keep the trial bit only while the input is at or above it
	assign msb      = {1'b1, {(W-1){1'b0}}};
	assign keep     = comp ? code : (code & ~bit_r); // [RQ1]
	assign next_bit = bit_r >> 1;

	// Load starts at mid-scale, each step settles one bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			code  <= '0;
			bit_r <= '0;
		end else if (load) begin
			code  <= msb;
			bit_r <= msb;
		end else if (step && bit_r != '0) begin
			code  <= keep | next_bit;
			bit_r <= next_bit;
		end
	end

	// Low comparator drops the bit just tried
	sar_drop_a: assert property (@(posedge clk) disable iff (!arst_n) // [RQ1]
		(step && !load && !comp && bit_r != '0) |=> ((code & $past(bit_r)) == '0))
		else $error("rejected trial bit kept");
endmodule
`default_nettype wire

// [verilog/adcs_top.sv]
// Sequencer and register file for a 10-bit successive approximation converter.
// Assumes a single AHB-Lite master, a comparator pin and an analog mux outside.
//
// Function
// [RQ1] - Result code equals input times 1024 over reference, zero to all ones.
// [RQ2] - Reference field: external pin, analog supply, reserved, internal reference.
// [RQ3] - Reference and channel writes during a conversion apply after it finishes.
// [RQ4] - Left adjust bit re-presents result bytes at once, even mid conversion.
// [RQ5] - Channel field: inputs zero to seven, bandgap, ground, rest unassigned.
// [RQ6] - Enable powers converter; clearing it aborts any running conversion.
// [RQ7] - Start write begins conversion; free run needs only the first start.
// [RQ8] - First conversion after enable takes 25 cycles, later ones take 13.
// [RQ9] - Start bit reads one while converting; writing zero does nothing.
// [RQ10] - Free run bit keeps sampling and updating results; clearing ends it.
// [RQ11] - Done flag sets when conversion finishes and result is updated.
// [RQ12] - Interrupt requested only with flag, enable and global enable set.
// [RQ13] - Flag clears on vector acknowledge or writing one; zero leaves it.
// [RQ14] - Prescaler codes divide by 2,2,4,8,16,32,64,128.
// [RQ15] - Software should keep low analog port pins quiet while converting.
// [RQ16] - Low byte read freezes result until the high byte is read.
// [RQ17] - Conversion begins on first converter clock edge after start.
// [RQ18] - Sample and hold after 1.5 normal cycles, 13.5 on the first.
// [RQ19] - Free run restarts right after completion with start bit held high.
// [RQ20] - Prescaler counter runs on system clock, held clear while disabled.
// [RQ21] - Reset clears every control, selection and flag bit to zero.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module adcs_top (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	// Analog front end
	input  wire logic        COMP_IN,
	output var  logic [9:0]  DAC_CODE,
	output var  logic        SAMPLE_HOLD,
	output var  logic        CONVERTER_ON,
	output var  logic [3:0]  CHANNEL_SEL,
	output var  logic [7:0]  EXT_INPUT_SEL,
	output var  logic        BANDGAP_SEL,
	output var  logic        GROUND_SEL,
	output var  logic        SUPPLY_REF_SEL,
	output var  logic        INT_REF_ON,
	// Processor interrupt side
	input  wire logic        GLOBAL_IRQ_EN,
	input  wire logic        IRQ_ACK,
	output var  logic        DONE_IRQ
);
	import adcs_pkg::*;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic       wr_pend_r;
	logic       rd_pend_r;
	logic [7:0] addr_r;
	logic [7:0] wdata;
	logic [7:0] rd_val;
	logic       addr_phase;
	logic       wr_sel;
	logic       wr_ctl;

	// Address decode, writes commit in their data phase
	assign addr_phase = HSEL && HREADY && (HTRANS == ADCS_HTRANS_NONSEQ);
	assign wdata      = HWDATA[7:0];
	assign wr_sel     = wr_pend_r && (addr_r == ADCS_OFS_INPUT_SELECT);
	assign wr_ctl     = wr_pend_r && (addr_r == ADCS_OFS_CONTROL);

	// Reads take one wait state so a prior write is visible
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
			HREADYOUT <= 1'b1;
			HRDATA    <= 32'h0000_0000;
		end else begin
			wr_pend_r <= addr_phase && HWRITE;
			rd_pend_r <= addr_phase && !HWRITE;
			HREADYOUT <= !(addr_phase && !HWRITE);
			if (addr_phase)
				addr_r <= HADDR[7:0];
			if (rd_pend_r)
				HRDATA <= {24'h00_0000, rd_val};
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [1:0] ref_r;
	logic       left_r;
	logic [3:0] chan_r;
	logic       enable_r;
	logic       busy_r;
	logic       free_r;
	logic       flag_r;
	logic       irqen_r;
	logic [2:0] div_r;
	logic       freeze_r;
	logic [9:0] res_r;
	logic [7:0] res_low;
	logic [7:0] res_high;

	// Result presentation follows the adjust bit combinationally
	assign res_low  = left_r ? {res_r[1:0], 6'h00} : res_r[7:0]; // [RQ4]
	assign res_high = left_r ? res_r[9:2] : {6'h00, res_r[9:8]}; // [RQ4]

	// Read mux, unmapped addresses read zero
	assign rd_val = (addr_r == ADCS_OFS_INPUT_SELECT) ? {ref_r, left_r, 1'b0, chan_r} :
		(addr_r == ADCS_OFS_CONTROL) ? {enable_r, busy_r, free_r, flag_r, irqen_r, div_r} :
		(addr_r == ADCS_OFS_RESULT_LOW) ? res_low :
		(addr_r == ADCS_OFS_RESULT_HIGH) ? res_high : 8'h00;

	// Plain read/write fields
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{ref_r, left_r, chan_r} <= 7'h00; // [RQ21]
			{free_r, irqen_r, div_r} <= 5'h00; // [RQ21]
		end else begin
			if (wr_sel) begin
				ref_r  <= wdata[ADCS_BIT_REF_HI:ADCS_BIT_REF_LO];
				left_r <= wdata[ADCS_BIT_LEFT];
				chan_r <= wdata[ADCS_BIT_CHAN_HI:0];
			end
			if (wr_ctl) begin
				free_r  <= wdata[ADCS_BIT_FREE]; // [RQ10]
				irqen_r <= wdata[ADCS_BIT_IRQ_EN];
				div_r   <= wdata[ADCS_BIT_DIV_HI:0];
			end
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	adcs_state_e state_r;
	adcs_state_e state_nxt;
	logic [4:0]  cyc_r;
	logic [4:0]  cyc_nxt;
	logic [4:0]  off;
	logic        long_r;
	logic        first_r;
	logic        tick;
	logic        enable_nxt;
	logic        start_wr;
	logic        conv_start;
	logic        in_conv;
	logic        done;
	logic        restart;
	logic        sh_now;
	logic        step_now;
	logic        busy_nxt;
	logic        flag_nxt;
	logic        sel_load;
	logic        comp_meta_r;
	logic        comp_sync_r;
	logic [9:0]  sar_code;
	logic [3:0]  chan_lock_r;
	logic [1:0]  ref_lock_r;

	// Event decode on converter clock enables
	assign enable_nxt = wr_ctl ? wdata[ADCS_BIT_ENABLE] : enable_r;
	assign start_wr   = wr_ctl && wdata[ADCS_BIT_START] && wdata[ADCS_BIT_ENABLE]; // [RQ7]
	assign conv_start = (state_r == ADCS_IDLE) && busy_r && tick && enable_nxt; // [RQ17]
	assign in_conv    = (state_r == ADCS_CONV) && tick;
	assign off        = long_r ? ADCS_EXTRA : 5'h00; // [RQ8]
	assign sh_now     = in_conv && (cyc_r == ADCS_SH_CYC + off); // [RQ18]
	assign step_now   = in_conv && (cyc_r >= ADCS_STEP_FIRST + off) &&
		(cyc_r <= ADCS_STEP_LAST + off);
	assign done       = in_conv && (cyc_r == ADCS_CYC_NORMAL - 5'h01 + off); // [RQ8]
	assign restart    = done && free_r && enable_nxt; // [RQ19]
	assign sel_load   = (state_r == ADCS_IDLE) || restart; // [RQ3]

	// Start bit: set by a start write, held in free run, cleared on disable
	assign busy_nxt = enable_nxt && (start_wr || (busy_r && !(done && !free_r))); // [RQ9]
	// Hardware set wins over either clear
	assign flag_nxt = done || (flag_r && !IRQ_ACK &&
		!(wr_ctl && wdata[ADCS_BIT_FLAG])); // [RQ11] [RQ13]

	// Next state and cycle count
	always_comb begin
		state_nxt = state_r;
		cyc_nxt   = cyc_r;
		case (state_r)
			ADCS_IDLE: begin
				if (conv_start) begin
					state_nxt = ADCS_CONV;
					cyc_nxt   = 5'h00;
				end
			end
			ADCS_CONV: begin
				if (restart)
					cyc_nxt = 5'h00; // [RQ19]
				else if (done)
					state_nxt = ADCS_IDLE;
				else if (tick)
					cyc_nxt = cyc_r + 5'h01;
			end
			default: state_nxt = ADCS_IDLE;
		endcase
		if (!enable_nxt)
			state_nxt = ADCS_IDLE; // [RQ6]
	end

	// Control and status state
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r  <= ADCS_IDLE;
			cyc_r    <= 5'h00;
			enable_r <= 1'b0; // [RQ21]
			busy_r   <= 1'b0;
			flag_r   <= 1'b0;
			first_r  <= 1'b0;
			long_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			cyc_r    <= cyc_nxt;
			enable_r <= enable_nxt; // [RQ6]
			busy_r   <= busy_nxt;
			flag_r   <= flag_nxt;
			first_r  <= !enable_r || (first_r && !conv_start); // [RQ8]
			if (conv_start || restart)
				long_r <= conv_start && first_r; // [RQ8]
		end
	end

	// Result update and read freeze between low and high reads
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			res_r    <= 10'h000;
			freeze_r <= 1'b0;
		end else begin
			if (done && !freeze_r)
				res_r <= sar_code; // [RQ1] [RQ10]
			if (rd_pend_r && addr_r == ADCS_OFS_RESULT_LOW)
				freeze_r <= 1'b1; // [RQ16]
			else if (rd_pend_r && addr_r == ADCS_OFS_RESULT_HIGH)
				freeze_r <= 1'b0;
		end
	end

	// Comparator pin synchroniser
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			comp_meta_r <= 1'b0;
			comp_sync_r <= 1'b0;
		end else begin
			comp_meta_r <= COMP_IN;
			comp_sync_r <= comp_meta_r;
		end
	end

	adcs_prescaler u_prescaler (
		.clk    (CLK),
		.arst_n (ARST_N),
		.enable (enable_r),
		.sel    (div_r),
		.tick   (tick)
	);

	adcs_sar #(
		.W (ADCS_RES_W)
	) u_sar (
		.clk    (CLK),
		.arst_n (ARST_N),
		.load   (sh_now),
		.step   (step_now),
		.comp   (comp_sync_r),
		.code   (sar_code)
	);

	// ****************************************************************
	// Analog selection and outputs
	// ****************************************************************
	// Selections track the register until locked by a conversion
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			chan_lock_r    <= 4'h0;
			ref_lock_r     <= 2'h0;
			INT_REF_ON     <= 1'b0;
			SUPPLY_REF_SEL <= 1'b0;
			BANDGAP_SEL    <= 1'b0;
			GROUND_SEL     <= 1'b0;
			SAMPLE_HOLD    <= 1'b0;
			CONVERTER_ON   <= 1'b0;
			DONE_IRQ       <= 1'b0;
		end else begin
			if (sel_load) begin
				chan_lock_r <= chan_r; // [RQ3]
				ref_lock_r  <= ref_r; // [RQ3]
			end
			INT_REF_ON     <= ref_lock_r == ADCS_REF_INTERNAL; // [RQ2]
			SUPPLY_REF_SEL <= ref_lock_r == ADCS_REF_SUPPLY; // [RQ2]
			BANDGAP_SEL    <= chan_lock_r == ADCS_CH_BANDGAP; // [RQ5]
			GROUND_SEL     <= chan_lock_r == ADCS_CH_GROUND; // [RQ5]
			SAMPLE_HOLD    <= sh_now; // [RQ18]
			CONVERTER_ON   <= enable_r;
			DONE_IRQ       <= flag_r && irqen_r && GLOBAL_IRQ_EN; // [RQ12]
		end
	end

	// One-hot external input select, unassigned codes select nothing
	generate
		for (genvar i = 0; i < 8; i++) begin : g_ext
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N)
					EXT_INPUT_SEL[i] <= 1'b0;
				else
					EXT_INPUT_SEL[i] <= (chan_lock_r == 4'(i)); // [RQ5]
			end
		end
	endgenerate

	assign CHANNEL_SEL = chan_lock_r;
	assign DAC_CODE    = sar_code;
	assign HRESP       = 1'b0;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	flag_set_a: assert property (done |=> flag_r) // [RQ11]
		else $error("done flag not set");
	flag_clear_a: assert property ((wr_ctl && wdata[ADCS_BIT_FLAG] && !done) |=> !flag_r) // [RQ13]
		else $error("flag not cleared by write one");
	irq_gate_a: assert property (DONE_IRQ == $past(flag_r && irqen_r && GLOBAL_IRQ_EN)) // [RQ12]
		else $error("interrupt gating wrong");
	disable_abort_a: assert property ((wr_ctl && !wdata[ADCS_BIT_ENABLE]) |=> // [RQ6]
		(state_r == ADCS_IDLE && !busy_r))
		else $error("disable did not abort");
	sel_locked_a: assert property ((state_r == ADCS_CONV && !restart && !$past(restart)) |-> // [RQ3]
		$stable(chan_lock_r) && $stable(ref_lock_r))
		else $error("selection moved mid conversion");
	first_long_a: assert property ((conv_start && first_r) |=> long_r ##0 // [RQ8]
		(!done throughout (state_r == ADCS_CONV && cyc_r < 5'h18)))
		else $error("first conversion not long");
	start_held_a: assert property ((busy_r && state_r == ADCS_CONV && !done && enable_nxt) |=> // [RQ9]
		busy_r)
		else $error("start bit dropped mid conversion");
	free_restart_a: assert property (restart |=> (state_r == ADCS_CONV && busy_r && cyc_r == 5'h00)) // [RQ19]
		else $error("free run did not restart");
	freeze_hold_a: assert property ((freeze_r && done) |=> $stable(res_r)) // [RQ16]
		else $error("frozen result updated");
	start_edge_a: assert property ((state_r == ADCS_IDLE && busy_r && enable_nxt && tick) |=> // [RQ17]
		state_r == ADCS_CONV)
		else $error("conversion missed first edge");
endmodule
`default_nettype wire

// [testbench/tb_adcs_top.sv]
// Self-checking bench for the converter sequencer control block.
// Assumes one AHB-Lite master (this bench) and a comparator modelled from DAC_CODE.
`default_nettype none
module tb_adcs_top;
	import adcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        CLK;
	logic        ARST_N;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA;
	wire  logic  HREADY;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic        COMP_IN;
	logic [9:0]  DAC_CODE;
	logic        SAMPLE_HOLD;
	logic        CONVERTER_ON;
	logic [3:0]  CHANNEL_SEL;
	logic [7:0]  EXT_INPUT_SEL;
	logic        BANDGAP_SEL;
	logic        GROUND_SEL;
	logic        SUPPLY_REF_SEL;
	logic        INT_REF_ON;
	logic        GLOBAL_IRQ_EN;
	logic        IRQ_ACK;
	logic        DONE_IRQ;
	logic [9:0]  vin;
	int          miscompares;
	int          n_tests;
	int          cyc;

	// Single slave, so its ready is the bus ready
	assign HREADY = HREADYOUT;

	adcs_top u_dut (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .COMP_IN(COMP_IN), .DAC_CODE(DAC_CODE),
		.SAMPLE_HOLD(SAMPLE_HOLD), .CONVERTER_ON(CONVERTER_ON), .CHANNEL_SEL(CHANNEL_SEL),
		.EXT_INPUT_SEL(EXT_INPUT_SEL), .BANDGAP_SEL(BANDGAP_SEL), .GROUND_SEL(GROUND_SEL),
		.SUPPLY_REF_SEL(SUPPLY_REF_SEL), .INT_REF_ON(INT_REF_ON),
		.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_ACK(IRQ_ACK), .DONE_IRQ(DONE_IRQ));

	// ****************************************************************
	// Clock, comparator model, hang guard
	// ****************************************************************
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// Ideal comparator: high while the input is at or above the trial level
	always @(posedge CLK) COMP_IN <= (vin >= DAC_CODE);

	always @(posedge CLK) begin
		cyc++;
		if (cyc > 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ****************************************************************
	// Shared tasks, all entered and left just after a rising edge
	// ****************************************************************
	task automatic report_and_stop();
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Ready is settled by the falling edge and sampled at the next rising edge
	task automatic wait_rdy(output logic [31:0] r);
		logic ok;
		do begin
			@(negedge CLK);
			ok = HREADYOUT;
			r = HRDATA;
		end while (ok !== 1'b1);
		@(posedge CLK);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= ADCS_HTRANS_NONSEQ;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		wait_rdy(r);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= {24'h0, d};
		wait_rdy(r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 8'h00, r);
	endtask

	// Poll the start bit until it drops, then judge the elapsed cycles
	task automatic wait_done(input int t0, input int lo, input int hi);
		logic [31:0] r;
		do rd(ADCS_OFS_CONTROL, r); while (r[6] === 1'b1 && cyc - t0 < 5000);
		chk(32'((cyc - t0 >= lo) && (cyc - t0 <= hi)), 32'h1, "conversion length");
	endtask

	task automatic wait_sh(output int t);
		do @(negedge CLK); while (SAMPLE_HOLD !== 1'b1);
		t = cyc;
		@(posedge CLK);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		logic [31:0] r;
		logic [7:0]  addrs [5];
		addrs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};
		foreach (addrs[i]) begin
			rd(addrs[i], r);
			chk(r, 32'h0, "reset or unmapped read");
		end
		chk(32'(HRESP), 32'h0, "response");
	endtask

	task automatic t_select();
		logic [31:0] r;
		logic [7:0]  v;
		for (int i = 0; i < 16; i++) begin
			v = {2'(i), 2'b01, 4'(i)};
			wr(ADCS_OFS_INPUT_SELECT, v);
			rd(ADCS_OFS_INPUT_SELECT, r);
			chk(r, {24'h0, v & 8'hef}, "select readback");
			repeat (3) @(posedge CLK);
			chk(32'(EXT_INPUT_SEL), (i < 8) ? (32'h1 << i) : 32'h0, "ext input");
			chk({BANDGAP_SEL, GROUND_SEL}, {30'h0, i == 14, i == 15}, "internal inputs");
			chk({SUPPLY_REF_SEL, INT_REF_ON}, {30'h0, i % 4 == 1, i % 4 == 3}, "ref");
		end
	endtask

	task automatic t_single();
		logic [31:0] r;
		int          t0;
		vin = 10'h2c7;
		wr(ADCS_OFS_INPUT_SELECT, 8'h01);
		wr(ADCS_OFS_CONTROL, 8'hc3);
		t0 = cyc;
		wait_done(t0, 192, 216);
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h93, "done flag, start clear");
		chk(32'(DAC_CODE), 32'h2c7, "final trial code");
		rd(ADCS_OFS_RESULT_LOW, r);
		chk(r, 32'hc7, "right low");
		rd(ADCS_OFS_RESULT_HIGH, r);
		chk(r, 32'h02, "right high");
		wr(ADCS_OFS_CONTROL, 8'h83);
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h93, "flag kept on zero");
		wr(ADCS_OFS_CONTROL, 8'h93);
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h83, "flag cleared by one");
		wr(ADCS_OFS_CONTROL, 8'hc3);
		t0 = cyc;
		repeat (16) @(posedge CLK);
		wr(ADCS_OFS_INPUT_SELECT, 8'h05);
		repeat (3) @(posedge CLK);
		chk(32'(CHANNEL_SEL), 32'h1, "channel locked");
		wait_done(t0, 96, 120);
		chk(32'(CHANNEL_SEL), 32'h5, "channel applied after done");
		wr(ADCS_OFS_INPUT_SELECT, 8'h25);
		rd(ADCS_OFS_RESULT_LOW, r);
		chk(r, 32'hc0, "left low");
		vin = 10'h155; // Input moves only between conversions
		wr(ADCS_OFS_CONTROL, 8'hc3);
		wait_done(cyc, 96, 120);
		rd(ADCS_OFS_RESULT_HIGH, r);
		chk(r, 32'hb1, "frozen left high");
	endtask

	task automatic t_irq();
		logic [31:0] r;
		wr(ADCS_OFS_CONTROL, 8'h8b);
		repeat (3) @(posedge CLK);
		chk(32'(DONE_IRQ), 32'h0, "no global enable");
		GLOBAL_IRQ_EN <= 1'b1;
		repeat (3) @(posedge CLK);
		chk(32'(DONE_IRQ), 32'h1, "all enables");
		wr(ADCS_OFS_CONTROL, 8'h83);
		repeat (3) @(posedge CLK);
		chk(32'(DONE_IRQ), 32'h0, "irq enable off");
		wr(ADCS_OFS_CONTROL, 8'h8b);
		IRQ_ACK <= 1'b1;
		@(posedge CLK);
		IRQ_ACK <= 1'b0;
		repeat (3) @(posedge CLK);
		chk(32'(DONE_IRQ), 32'h0, "cleared by vector");
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h8b, "flag cleared by vector");
	endtask

	task automatic t_abort();
		logic [31:0] r;
		wr(ADCS_OFS_CONTROL, 8'hc3);
		repeat (40) @(posedge CLK);
		wr(ADCS_OFS_CONTROL, 8'h03);
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h03, "abort clears start");
		repeat (300) @(posedge CLK);
		rd(ADCS_OFS_CONTROL, r);
		chk(r, 32'h03, "no flag after abort");
		chk(32'(CONVERTER_ON), 32'h0, "converter off");
	endtask

	task automatic t_free();
		logic [31:0] r;
		int          t1;
		int          t2;
		int          t3;
		int          dv;
		for (int c = 0; c < 8; c++) begin
			dv = (c < 2) ? 2 : (1 << c);
			wr(ADCS_OFS_CONTROL, 8'h00);
			wr(ADCS_OFS_CONTROL, 8'he0 | 8'(c));
			wait_sh(t1);
			wait_sh(t2);
			wait_sh(t3);
			chk(32'(t3 - t2), 32'(13 * dv), "free run period");
			rd(ADCS_OFS_CONTROL, r);
			chk(32'(r[6]), 32'h1, "start held in free run");
			wr(ADCS_OFS_CONTROL, 8'h80 | 8'(c));
			repeat (16 * dv + 10) @(posedge CLK);
			rd(ADCS_OFS_CONTROL, r);
			chk(32'(r[6]), 32'h0, "free run ended");
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		ARST_N = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		COMP_IN = 1'b0;
		GLOBAL_IRQ_EN = 1'b0;
		IRQ_ACK = 1'b0;
		vin = 10'h0;
		miscompares = 0;
		n_tests = 0;
		cyc = 0;
		repeat (8) @(posedge CLK);
		ARST_N <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_select();
		t_single();
		t_irq();
		t_abort();
		t_free();
		report_and_stop();
	end
endmodule
`default_nettype wire
